// >>> ssq_host_model.sv
// Host model driving the input clock pin and the reset pin
`timescale 1ns/10ps
module ssq_host_model (
  // Clock
  input wire logic pclk,
  // Commands from the bench
  input wire logic clk_run,
  input wire logic rst_req,
  // Pins into the device
  output logic clock_pin,
  output logic external_reset_n
);
  logic pin_ff = 1'h0;
  // clock can stop
  // Stands still when stopped, so the watchdog sees no edge at all
  always @(posedge pclk) begin
    if (clk_run) begin
      pin_ff <= ~pin_ff;
    end
  end
  assign clock_pin = pin_ff;
  assign external_reset_n = ~rst_req;
endmodule

// >>> ssq_pkg.sv
// Package with constants and types of the supply and reset sequencer
package ssq_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_DIAG = 12'h000;
  localparam logic [11:0] OFS_CTRL = 12'h004;
  localparam logic [11:0] OFS_STAT = 12'h008;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h00C;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h010;

  // Diagnosis and interrupt bit positions (same layout)
  localparam int BIT_LOAD0 = 0;
  localparam int BIT_LOAD1 = 1;
  localparam int BIT_PUMP_UV = 2;
  localparam int BIT_PUMP_WARN = 3;
  localparam int BIT_RST = 4;
  localparam int EVT_W = 5;

  // Control bit positions
  localparam int BIT_CLOCK_WATCHDOG_ENABLE = 0;
  localparam int BIT_CHEN0 = 1;

  // Status bit positions
  localparam int BIT_READY = 0;
  localparam int BIT_SLEEP = 1;
  localparam int BIT_WD_FAULT = 2;
  localparam int BIT_FAULT_PIN = 3;

  // Synchroniser lanes
  localparam int SY_LOGIC = 0;
  localparam int SY_ANALOG = 1;
  localparam int SY_REF = 2;
  localparam int SY_LOAD0 = 3;
  localparam int SY_PUMP_UV = 5;
  localparam int SY_PUMP_WARN = 6;
  localparam int SY_EXT_RST = 7;
  localparam int SY_CLK_PIN = 8;
  localparam int SY_FAULT_IN = 9;
  localparam int SY_W = 10;

  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int POR_TIME_NS = 64000;
  localparam int POR_CYC = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLK_MISS_NS = 1000;
  localparam int MISS_CYC = CLK_MISS_NS / CLK_PERIOD_NS;

  // Reset values
  localparam logic [11:0] POR_CNT_RST = 12'h000;
  localparam logic [5:0] WD_CNT_RST = 6'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_SLEEP,
    ST_RESET,
    ST_HOLD,
    ST_RUN
  } ssq_state_type;

endpackage

// >>> ssq_sequencer.sv
// Supply supervision, reset and sleep sequencing with APB registers
//
// How it works
// RL1: Load supply low disables that channel's stage and flags it.
// RL2: Analog or reference supply low holds internal logic in reset.
// RL3: Logic supply low holds internal logic in reset.
// RL4: Reset held until supplies good, then fixed hold time before release.
// RL5: Port accesses refused until hold time elapsed; host waits too.
// RL6: Armed clock watchdog holds reset when input clock stops or slows.
// RL7: Every exit from reset sets the reset-occurred flag.
// RL8: Any access to the diagnosis register clears reset-occurred flag.
// RL9: Pump undervoltage disables output stages and sets its flag.
// RL10: Pump below warning level sets the separate warning flag.
// RL11: Pump between warning and undervoltage keeps outputs running.
// RL12: Any core supply low puts the device into sleep.
// RL13: Sleep ends by itself once all core supplies are good.
// RL14: Sleep acts as reset; exit runs the full hold sequence.
// RL15: External reset low keeps reset, fault low, port disabled.
// RL16: Hold count starts first cycle after external reset rises; here it starts only once the two-flop synchronised reset pin reads high.
// RL17: Fault output pulled low in every internal reset state.
// RL18: Supply monitor outputs synchronised before use.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module ssq_sequencer (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Supply monitors, high when above threshold
  input wire logic logic_supply,
  input wire logic analog_supply,
  input wire logic reference_supply,
  input wire logic [1:0] channel_load_supply,
  input wire logic pump_output_voltage,
  input wire logic pump_above_warning,
  // Host pins
  input wire logic external_reset_n,
  input wire logic clock_pin,
  // Open-drain fault pin
  input wire logic fault_out_n_i,
  output logic fault_out_n_o,
  output logic fault_out_n_oe_n,
  // Block outputs
  output logic [1:0] stage_enable,
  output logic internal_reset_n,
  output logic sleep_mode,
  output logic irq
);

  typedef struct packed {
    ssq_pkg::ssq_state_type state;
    logic [11:0] por_cnt;
    logic [5:0] wd_cnt;
    logic wd_fault;
    logic clk_prev;
    logic clock_watchdog_enable;
    logic [1:0] chen;
    logic diag_rst;
    logic [ssq_pkg::EVT_W-1:0] irq_stat;
    logic [ssq_pkg::EVT_W-1:0] irq_mask;
    logic [1:0] stage_en;
    logic [31:0] rdata;
  } ssq_regs_type;

  ssq_regs_type r_ff;
  ssq_regs_type nxt_r;
  logic [ssq_pkg::SY_W-1:0] raw;
  logic [ssq_pkg::SY_W-1:0] sy;
  logic supply_ok;
  logic ext_ok;
  logic [1:0] load_low;
  logic pump_uv;
  logic pump_warn;
  logic run;
  logic setup;
  logic access;
  logic mapped;
  logic wr_ok;
  logic acc_ok;
  logic clk_edge;
  logic [ssq_pkg::EVT_W-1:0] evt;
  logic [ssq_pkg::EVT_W-1:0] diag;

  assign raw = {fault_out_n_i, clock_pin, external_reset_n,
                pump_above_warning, pump_output_voltage,
                channel_load_supply, reference_supply, analog_supply,
                logic_supply};

  // RL18: synchronise monitor inputs
  ssq_sync #(
    .W(ssq_pkg::SY_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .async_in(raw),
    .sync_out(sy)
  );

  // RL12: any core supply low means sleep
  assign supply_ok = sy[ssq_pkg::SY_LOGIC] & sy[ssq_pkg::SY_ANALOG] &
                     sy[ssq_pkg::SY_REF];
  assign ext_ok = sy[ssq_pkg::SY_EXT_RST];
  assign load_low = ~sy[ssq_pkg::SY_LOAD0 +: 2];
  assign pump_uv = ~sy[ssq_pkg::SY_PUMP_UV];
  assign pump_warn = ~sy[ssq_pkg::SY_PUMP_WARN];
  assign run = (r_ff.state == ssq_pkg::ST_RUN);
  assign clk_edge = sy[ssq_pkg::SY_CLK_PIN] & ~r_ff.clk_prev;

  // APB decode; zero wait states
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign mapped = (paddr == ssq_pkg::OFS_DIAG) ||
                  (paddr == ssq_pkg::OFS_CTRL) ||
                  (paddr == ssq_pkg::OFS_STAT) ||
                  (paddr == ssq_pkg::OFS_IRQ_STAT) ||
                  (paddr == ssq_pkg::OFS_IRQ_MASK);
  // RL5: refuse access until released
  assign acc_ok = access & run & mapped;
  assign wr_ok = acc_ok & pwrite;
  assign pready = 1'b1;
  assign pslverr = access & ~(run & mapped);
  assign prdata = r_ff.rdata;

  // RL1: load flags live in diagnosis
  always_comb begin
    diag = '0;
    diag[ssq_pkg::BIT_LOAD0] = load_low[0];
    diag[ssq_pkg::BIT_LOAD1] = load_low[1];
    diag[ssq_pkg::BIT_PUMP_UV] = pump_uv;
    diag[ssq_pkg::BIT_PUMP_WARN] = pump_warn;
    diag[ssq_pkg::BIT_RST] = r_ff.diag_rst;
  end

  always_comb begin
    nxt_r = r_ff;
    evt = '0;
    nxt_r.clk_prev = sy[ssq_pkg::SY_CLK_PIN];

    // RL6: watchdog counts cycles between rising clock pin edges
    if (clk_edge) begin
      nxt_r.wd_cnt = ssq_pkg::WD_CNT_RST;
    end else if (r_ff.wd_cnt != 6'(ssq_pkg::MISS_CYC)) begin
      nxt_r.wd_cnt = r_ff.wd_cnt + 6'h01;
    end
    // Latched until external reset or power loss
    if (!ext_ok || !supply_ok) begin
      nxt_r.wd_fault = 1'b0;
    end else if (r_ff.clock_watchdog_enable && r_ff.wd_cnt == 6'(ssq_pkg::MISS_CYC)) begin
      nxt_r.wd_fault = 1'b1;
    end

    case (r_ff.state)
      ssq_pkg::ST_SLEEP: begin
        // RL13: leave sleep without host action
        if (supply_ok) begin
          nxt_r.state = ssq_pkg::ST_RESET;
        end
      end
      ssq_pkg::ST_RESET: begin
        // RL16: hold count starts right after release
        if (ext_ok && !r_ff.wd_fault) begin
          nxt_r.state = ssq_pkg::ST_HOLD;
          nxt_r.por_cnt = ssq_pkg::POR_CNT_RST;
        end
      end
      ssq_pkg::ST_HOLD: begin
        // RL4: fixed hold before release
        if (r_ff.por_cnt == 12'(ssq_pkg::POR_CYC - 1)) begin
          nxt_r.state = ssq_pkg::ST_RUN;
          evt[ssq_pkg::BIT_RST] = 1'b1;
        end else begin
          nxt_r.por_cnt = r_ff.por_cnt + 12'h001;
        end
      end
      ssq_pkg::ST_RUN: begin
        nxt_r.state = ssq_pkg::ST_RUN;
      end
      default: begin
        nxt_r.state = ssq_pkg::ST_SLEEP;
      end
    endcase

    // RL15: external reset overrides, watchdog too
    if (!ext_ok || r_ff.wd_fault) begin
      nxt_r.state = ssq_pkg::ST_RESET;
      evt[ssq_pkg::BIT_RST] = 1'b0;
    end
    // RL2: supply loss wins over all
    // RL3: logic supply included
    // RL14: sleep restarts whole sequence
    if (!supply_ok) begin
      nxt_r.state = ssq_pkg::ST_SLEEP;
      evt[ssq_pkg::BIT_RST] = 1'b0;
    end

    // Internal reset clears software control
    if (!run) begin
      nxt_r.clock_watchdog_enable = 1'b0;
      nxt_r.chen = 2'b00;
    end

    // Register writes
    if (wr_ok) begin
      if (paddr == ssq_pkg::OFS_CTRL) begin
        nxt_r.clock_watchdog_enable = pwdata[ssq_pkg::BIT_CLOCK_WATCHDOG_ENABLE];
        nxt_r.chen = pwdata[ssq_pkg::BIT_CHEN0 +: 2];
      end else if (paddr == ssq_pkg::OFS_IRQ_STAT) begin
        nxt_r.irq_stat = r_ff.irq_stat & ~pwdata[ssq_pkg::EVT_W-1:0];
      end else if (paddr == ssq_pkg::OFS_IRQ_MASK) begin
        nxt_r.irq_mask = pwdata[ssq_pkg::EVT_W-1:0];
      end
    end

    // RL8: diagnosis access clears reset flag
    if (acc_ok && paddr == ssq_pkg::OFS_DIAG) begin
      nxt_r.diag_rst = 1'b0;
    end
    // RL7: exit from reset sets flag; set wins
    if (evt[ssq_pkg::BIT_RST]) begin
      nxt_r.diag_rst = 1'b1;
    end

    // RL10: warning flag source
    evt[ssq_pkg::BIT_PUMP_WARN] = pump_warn;
    evt[ssq_pkg::BIT_PUMP_UV] = pump_uv;
    evt[ssq_pkg::BIT_LOAD0] = load_low[0];
    evt[ssq_pkg::BIT_LOAD1] = load_low[1];
    // Set after clear so a same-cycle event survives
    nxt_r.irq_stat = nxt_r.irq_stat | evt;

    // RL1: per-channel load supply gate
    // RL9: pump undervoltage gate
    // RL11: warning alone does not gate
    // Outputs stay off until watchdog armed
    nxt_r.stage_en = (run && r_ff.clock_watchdog_enable && !pump_uv) ?
                     (r_ff.chen & ~load_low) : 2'b00;

    // Read data captured in setup phase
    if (setup) begin
      if (paddr == ssq_pkg::OFS_DIAG) begin
        nxt_r.rdata = {27'h000_0000, diag};
      end else if (paddr == ssq_pkg::OFS_CTRL) begin
        nxt_r.rdata = {29'h0000_0000, r_ff.chen, r_ff.clock_watchdog_enable};
      end else if (paddr == ssq_pkg::OFS_STAT) begin
        nxt_r.rdata = {28'h000_0000, sy[ssq_pkg::SY_FAULT_IN],
                       r_ff.wd_fault,
                       r_ff.state == ssq_pkg::ST_SLEEP, run};
      end else if (paddr == ssq_pkg::OFS_IRQ_STAT) begin
        nxt_r.rdata = {27'h000_0000, r_ff.irq_stat};
      end else if (paddr == ssq_pkg::OFS_IRQ_MASK) begin
        nxt_r.rdata = {27'h000_0000, r_ff.irq_mask};
      end else begin
        nxt_r.rdata = ssq_pkg::RDATA_RST;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff <= '{state: ssq_pkg::ST_SLEEP,
                por_cnt: ssq_pkg::POR_CNT_RST,
                wd_cnt: ssq_pkg::WD_CNT_RST,
                rdata: ssq_pkg::RDATA_RST,
                default: '0};
    end else if (ce) begin
      r_ff <= nxt_r;
    end
  end

  // RL17: fault pin low in reset or on supply faults
  assign fault_out_n_o = 1'b0;
  assign fault_out_n_oe_n = run & ~pump_uv & ~(|load_low);
  assign stage_enable = r_ff.stage_en;
  assign internal_reset_n = run;
  assign sleep_mode = (r_ff.state == ssq_pkg::ST_SLEEP);
  assign irq = |(r_ff.irq_stat & r_ff.irq_mask);

  // Checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_hold_end;
    r_ff.state == ssq_pkg::ST_HOLD ##1 r_ff.state == ssq_pkg::ST_RUN;
  endsequence

  sequence s_diag_acc;
    ce && acc_ok && paddr == ssq_pkg::OFS_DIAG && !evt[ssq_pkg::BIT_RST];
  endsequence

  chk_load_gate: assert property ( // RL1
    ce && load_low[0] |=> !stage_enable[0])
    else $error("stage on with load supply low");

  chk_analog_sleep: assert property ( // RL2
    ce && !(sy[ssq_pkg::SY_ANALOG] && sy[ssq_pkg::SY_REF])
    |=> sleep_mode && !internal_reset_n)
    else $error("analog supply low not in reset");

  chk_logic_sleep: assert property ( // RL3
    ce && !sy[ssq_pkg::SY_LOGIC] |=> sleep_mode)
    else $error("logic supply low not in reset");

  chk_hold_time: assert property ( // RL4
    s_hold_end |-> $past(r_ff.por_cnt) == 12'(ssq_pkg::POR_CYC - 1))
    else $error("released before hold time");

  chk_port_refused: assert property ( // RL5
    access && !run |-> pslverr && !wr_ok)
    else $error("access accepted during reset");

  chk_wd_reset: assert property ( // RL6
    ce && r_ff.wd_fault |=> r_ff.state != ssq_pkg::ST_RUN ##1
    r_ff.state != ssq_pkg::ST_HOLD)
    else $error("watchdog fault did not reset");

  chk_rst_flag: assert property ( // RL7
    s_hold_end |-> r_ff.diag_rst)
    else $error("reset flag not set on exit");

  chk_diag_clear: assert property ( // RL8
    s_diag_acc |=> !r_ff.diag_rst)
    else $error("diagnosis access left flag set");

  chk_pump_gate: assert property ( // RL9
    ce && pump_uv |=> stage_enable == 2'b00)
    else $error("stage on with pump undervoltage");

  chk_warn_runs: assert property ( // RL11
    ce && run && pump_warn && !pump_uv && r_ff.clock_watchdog_enable && r_ff.chen[0] &&
    !load_low[0] && !$past(pump_uv) ##1 run |-> stage_enable[0])
    else $error("warning alone disabled stage");

  chk_sleep_exit: assert property ( // RL13
    ce && sleep_mode && supply_ok |=> !sleep_mode)
    else $error("sleep not left with supplies good");

  chk_fault_reset: assert property ( // RL17
    !run |-> !fault_out_n_oe_n)
    else $error("fault pin released during reset");

endmodule

// >>> ssq_sequencer_test.sv
// Self-checking bench of the supply and reset sequencer
`timescale 1ns/10ps
module ssq_sequencer_test;
  localparam int HOLD = ssq_pkg::POR_CYC;
  localparam int MISS = ssq_pkg::MISS_CYC;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] sup = 3'h7;
  logic [1:0] load = 2'h3;
  logic pump_ok = 1'h1;
  logic warn_ok = 1'h1;
  logic clk_run = 1'h1;
  logic ce = 1'h1;
  logic rst_req = 1'h1;
  logic clock_pin;
  logic ext_rst_n;
  logic fault_o;
  logic fault_oe_n;
  logic fault_pin;
  logic [1:0] stage_enable;
  logic internal_reset_n;
  logic sleep_mode;
  logic irq;
  int failures = 0;
  int compares = 0;
  logic [31:0] seed;

  always #12.5 pclk = ~pclk;
  // Open-drain pin with pull-up
  assign fault_pin = fault_oe_n ? 1'h1 : fault_o;

  ssq_host_model host (.pclk(pclk), .clk_run(clk_run), .rst_req(rst_req),
    .clock_pin(clock_pin), .external_reset_n(ext_rst_n));

  ssq_sequencer dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .logic_supply(sup[0]), .analog_supply(sup[1]),
    .reference_supply(sup[2]), .channel_load_supply(load),
    .pump_output_voltage(pump_ok), .pump_above_warning(warn_ok),
    .external_reset_n(ext_rst_n), .clock_pin(clock_pin),
    .fault_out_n_i(fault_pin), .fault_out_n_o(fault_o),
    .fault_out_n_oe_n(fault_oe_n), .stage_enable(stage_enable),
    .internal_reset_n(internal_reset_n), .sleep_mode(sleep_mode),
    .irq(irq));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task complete_run();
    $display("Mismatches %0d, compares %0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task tmo();
    failures++;
    $display("Error wait expected completion seen timeout");
    complete_run();
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (i == 16) tmo();
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task rd(input logic [11:0] a, output logic [31:0] q, output logic e);
    apb(1'h0, a, 32'h0000_0000, q, e);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'h1, a, d, q, e);
  endtask

  // Bounded wait on run (0) or sleep (1)
  task wait_sig(input int s, input logic v, input int n, output int c);
    for (c = 0; c < n; c++) begin
      @(posedge pclk);
      #1;
      if ((s == 0 ? internal_reset_n : sleep_mode) === v) return;
    end
    tmo();
  endtask

  task hold_check();
    int c;
    wait_sig(0, 1'h1, HOLD + 50, c);
    chk("hold_len", c >= HOLD && c <= HOLD + 8, 1);
  endtask

  task ext_reset();
    logic [31:0] q;
    logic e;
    @(posedge pclk);
    rst_req <= 1'h1;
    tick(6);
    chk("rst_held", internal_reset_n, 0);
    chk("rst_fault", fault_pin, 0);
    rd(ssq_pkg::OFS_STAT, q, e);
    chk("early_err", e, 1);
    @(posedge pclk);
    rst_req <= 1'h0;
    hold_check();
  endtask

  initial begin
    logic [31:0] q;
    logic [31:0] r;
    logic e;
    int c;
    int k;
    seed = 32'h0000_003A;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    ext_reset();
    rd(ssq_pkg::OFS_DIAG, q, e);
    chk("diag_rst", q, 32'h0000_0010);
    chk("diag_err", e, 0);
    rd(ssq_pkg::OFS_DIAG, q, e);
    chk("diag_clr", q, 32'h0000_0000);
    chk("run_fault", fault_pin, 1);
    rd(12'h014, q, e);
    chk("unmapped", e, 1);
    wr(ssq_pkg::OFS_IRQ_STAT, 32'h0000_001F);
    r = rnd();
    wr(ssq_pkg::OFS_IRQ_MASK, r);
    rd(ssq_pkg::OFS_IRQ_MASK, q, e);
    chk("mask", q, r & 32'h0000_001F);
    rd(ssq_pkg::OFS_IRQ_STAT, q, e);
    chk("irq_stat", q, 32'h0000_0000);
    chk("irq_idle", irq, 0);
    wr(ssq_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    wr(ssq_pkg::OFS_CTRL, 32'h0000_0007);
    rd(ssq_pkg::OFS_CTRL, q, e);
    chk("ctrl", q, 32'h0000_0007);
    tick(4);
    chk("stage_on", stage_enable, 2'h3);
    @(posedge pclk);
    load <= 2'h2;
    tick(5);
    chk("stage_l0", stage_enable, 2'h2);
    chk("irq_l0", irq, 1);
    chk("fault_l0", fault_pin, 0);
    rd(ssq_pkg::OFS_DIAG, q, e);
    chk("diag_l0", q, 32'h0000_0001);
    @(posedge pclk);
    load <= 2'h3;
    tick(4);
    wr(ssq_pkg::OFS_IRQ_STAT, 32'h0000_0001);
    tick(2);
    chk("irq_clr", irq, 0);
    @(posedge pclk);
    warn_ok <= 1'h0;
    tick(5);
    chk("stage_warn", stage_enable, 2'h3);
    chk("fault_warn", fault_pin, 1);
    rd(ssq_pkg::OFS_DIAG, q, e);
    chk("diag_warn", q, 32'h0000_0008);
    @(posedge pclk);
    pump_ok <= 1'h0;
    tick(5);
    chk("stage_uv", stage_enable, 2'h0);
    rd(ssq_pkg::OFS_DIAG, q, e);
    chk("diag_uv", q, 32'h0000_000C);
    @(posedge pclk);
    pump_ok <= 1'h1;
    warn_ok <= 1'h1;
    tick(5);
    chk("stage_back", stage_enable, 2'h3);
    // Frozen clock enable hides a load drop until it resumes
    @(posedge pclk);
    ce <= 1'h0;
    load <= 2'h2;
    tick(6);
    chk("ce_freeze", stage_enable, 2'h3);
    @(posedge pclk);
    ce <= 1'h1;
    tick(5);
    chk("ce_resume", stage_enable, 2'h2);
    @(posedge pclk);
    load <= 2'h3;
    tick(5);
    chk("ce_back", stage_enable, 2'h3);
    // Watchdog armed, input clock stops
    @(posedge pclk);
    clk_run <= 1'h0;
    wait_sig(0, 1'h0, MISS + 20, c);
    chk("wd_delay", c >= MISS - 4 && c <= MISS + 6, 1);
    tick(2);
    chk("wd_fault", fault_pin, 0);
    chk("wd_stage", stage_enable, 2'h0);
    @(posedge pclk);
    clk_run <= 1'h1;
    ext_reset();
    // Pin readback needs its two sync stages
    tick(3);
    rd(ssq_pkg::OFS_STAT, q, e);
    chk("stat", q, 32'h0000_0009);
    rd(ssq_pkg::OFS_DIAG, q, e);
    chk("diag_wd", q, 32'h0000_0010);
    for (k = 0; k < 3; k++) begin
      @(posedge pclk);
      sup[k] <= 1'h0;
      wait_sig(1, 1'h1, 4, c);
      chk("sleep_rst", internal_reset_n, 0);
      tick(int'(rnd() % 16) + 2);
      chk("sleep_stay", sleep_mode, 1);
      @(posedge pclk);
      sup[k] <= 1'h1;
      hold_check();
      chk("sleep_exit", sleep_mode, 0);
      rd(ssq_pkg::OFS_DIAG, q, e);
      chk("diag_wake", q, 32'h0000_0010);
    end
    complete_run();
  end
endmodule

// >>> ssq_sync.sv
// Two-flop synchroniser, one lane per bit
`timescale 1ns/10ps
module ssq_sync #(
  parameter int W = 1
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Lanes
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      logic meta_ff;
      logic sync_ff;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
        end else if (ce) begin
          meta_ff <= async_in[i];
          sync_ff <= meta_ff;
        end
      end
      assign sync_out[i] = sync_ff;
    end
  endgenerate

endmodule
